// File: hw/pcm_pkg.sv
// package: register map, field layout, reset values and mode types of the clock-mode controller
package pcm_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS    = 12'h000;  // osc enable, pll select, timer clock selects
  localparam logic [11:0] SYNTH_OFS   = 12'h004;  // synthesizer multiplier
  localparam logic [11:0] REFERENCE_DIVIDER_OFS  = 12'h008;  // reference divider
  localparam logic [11:0] PLL_POST_DIVIDER_OFS = 12'h00C;  // pll post divider
  localparam logic [11:0] FILT_OFS    = 12'h010;  // spike filter setting
  localparam logic [11:0] STATUS_OFS  = 12'h014;  // mode, lock, qualified (read only)

  // control field positions
  localparam int CTRL_OSC_ENABLE_BIT_BIT   = 0;
  localparam int CTRL_PLL_SELECT_BIT_BIT = 1;
  localparam int CTRL_WDSEL_BIT  = 2;
  localparam int CTRL_RTSEL_BIT  = 3;

  // status field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_QUAL_BIT = 3;

  // reset values: internal reference pll giving 64 MHz vco, 16 MHz pll, 8 MHz bus
  localparam logic [5:0] SYNTH_RST   = 6'h1F;  // vco = 2 * 1 MHz * (31+1) = 64 MHz
  localparam logic [5:0] REFERENCE_DIVIDER_RST  = 6'h00;
  localparam logic [4:0] PLL_POST_DIVIDER_RST = 5'h03;  // pll = vco / (3+1) = 16 MHz
  localparam logic [4:0] FILT_RST    = 5'h00;
  localparam logic [3:0] CTRL_RST    = 4'h2;   // pll select set, oscillator off

  // vco sample counts per oscillator period are compared against filter*2, give some slack
  localparam logic [5:0] FILT_SLACK  = 6'h02;

  // run clock modes
  typedef enum logic [1:0] {
    PLL_INTERNAL_REF_MODE,
    PLL_EXTERNAL_REF_MODE,
    PLL_BYPASSED_EXTERNAL_MODE
  } pcm_mode_e;

  // settings driven out to the analog pll
  typedef struct packed {
    logic [5:0] synth;
    logic [5:0] reference_divider;
    logic [4:0] pll_post_divider;
    logic       ext_ref;
  } pcm_pll_cfg_s;

endpackage : pcm_pkg

// File: hw/pcm_spike_filter.sv
// oscillator qualifier: counts vco samples between oscillator edges
`timescale 1ns/1ps
module pcm_spike_filter #(
  parameter int FILT_W = 5
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              enable_in,
  input  wire logic              vco_tick_in,
  input  wire logic              osc_level_in,
  input  wire logic [FILT_W-1:0] setting_in,
  output logic                   qualified_out
);

  logic              osc_prev_q;
  logic [FILT_W+1:0] cnt_q;
  logic [2:0]        good_q;
  logic              edge_w;
  logic [FILT_W+1:0] lo_w;
  logic [FILT_W+1:0] hi_w;

  // one oscillator period spans setting*2 vco samples; accept a small window around it
  assign edge_w = vco_tick_in && osc_level_in && !osc_prev_q;
  assign lo_w   = {1'b0, setting_in, 1'b0} - (FILT_W+2)'(pcm_pkg::FILT_SLACK);
  assign hi_w   = {1'b0, setting_in, 1'b0} + (FILT_W+2)'(pcm_pkg::FILT_SLACK);

  // sample the oscillator on vco ticks and count ticks between rising edges
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      osc_prev_q <= 1'b0;
      cnt_q      <= '0;
    end else if (vco_tick_in) begin
      osc_prev_q <= osc_level_in;
      cnt_q      <= edge_w ? '0 : ((&cnt_q) ? cnt_q : cnt_q + 1'b1);
    end
  end

  // qualified after several good periods; any bad or missing period drops it
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      good_q        <= 3'h0;
      qualified_out <= 1'b0;
    end else if (vco_tick_in) begin
      if ((edge_w && (cnt_q < lo_w || cnt_q > hi_w)) || cnt_q > hi_w) begin
        good_q        <= 3'h0;
        qualified_out <= 1'b0;
      end else if (edge_w) begin
        good_q        <= (&good_q) ? good_q : good_q + 3'h1;
        qualified_out <= (&good_q);
      end
    end
  end

endmodule : pcm_spike_filter

// File: hw/pcm_clock_mode_ctrl.sv
// clock-mode controller: apb registers, run mode selection, oscillator qualification
//
// Behaviour
// - three run modes: internal-ref pll, external-ref pll, bypassed external.
// - any reset enters internal-ref pll mode, 8 MHz bus default.
// - after reset or full stop start from internal reference, oscillator off.
// - defaults give 64 MHz vco, post divider 3, 16 MHz pll, half bus.
// - internal-ref mode clocks watchdog and realtime timer from internal reference.
// - oscillator failure in external-ref pll mode falls back to defaults.
// - qualified flag plus pll select cleared gives bypassed mode.
// - pll select set returns external mode; osc enable cleared returns internal.
// - spike filter qualifies oscillator using locked vco samples.
// - lock loss clears the oscillator qualified flag.
// - external modes pick timer clocks by their own select bits.
// - pll keeps running in bypassed mode for the filter.
// - qualification loss in bypass sets pll select, bus back to pll.
`timescale 1ns/1ps
module pcm_clock_mode_ctrl #(
  parameter int FILT_W = 5
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic [31:0]               prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // analog pll and oscillator side
  input  wire logic                 pll_lock_in,
  input  wire logic                 vco_tick_in,
  input  wire logic                 osc_level_in,
  input  wire logic                 full_stop_exit_in,
  output pcm_pkg::pcm_pll_cfg_s     pll_cfg_out,
  output logic                      pll_enable_out,
  output logic                      osc_enable_out,
  // clock steering
  output logic                      bus_from_osc_out,
  output logic                      bus_switching_out,
  output logic                      watchdog_ext_clk_out,
  output logic                      rti_ext_clk_out,
  output pcm_pkg::pcm_mode_e        mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic              osc_enable_bit_q;
  logic              pll_select_bit_q;
  logic              wd_sel_q;
  logic              rt_sel_q;
  logic [5:0]        synth_q;
  logic [5:0]        reference_divider_q;
  logic [4:0]        post_q;
  logic [FILT_W-1:0] spike_filter_setting_q;
  logic              osc_qualified_flag;
  logic              filt_qual_w;
  logic              lock_q;
  logic              lock_fall_w;
  logic              qual_fall_w;
  logic              qualified_prev_q;
  logic              wr_w;
  logic              rd_w;
  logic              hit_w;
  logic [31:0]       rdata_d;
  pcm_pkg::pcm_mode_e mode_d;
  pcm_pkg::pcm_mode_e mode_q;
  logic              want_osc_w;
  logic              src_osc_q;
  logic [1:0]        sw_cnt_q;

  // a write completes in the access cycle; pready is a registered single-cycle answer
  assign wr_w = psel_in && penable_in && pwrite_in && !pready_out;
  assign rd_w = psel_in && penable_in && !pwrite_in && !pready_out;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == pcm_pkg::CTRL_OFS)    || (a == pcm_pkg::SYNTH_OFS)  ||
               (a == pcm_pkg::REFERENCE_DIVIDER_OFS)  || (a == pcm_pkg::PLL_POST_DIVIDER_OFS) ||
               (a == pcm_pkg::FILT_OFS)    || (a == pcm_pkg::STATUS_OFS);
  endfunction : addr_hit

  assign hit_w = addr_hit(paddr_in);

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: answer one cycle after the access phase starts

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !hit_w;
      prdata_out  <= rd_w ? rdata_d : 32'h0000_0000;
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr_in)
      pcm_pkg::CTRL_OFS: begin
        rdata_d[pcm_pkg::CTRL_OSC_ENABLE_BIT_BIT]   = osc_enable_bit_q;
        rdata_d[pcm_pkg::CTRL_PLL_SELECT_BIT_BIT] = pll_select_bit_q;
        rdata_d[pcm_pkg::CTRL_WDSEL_BIT]  = wd_sel_q;
        rdata_d[pcm_pkg::CTRL_RTSEL_BIT]  = rt_sel_q;
      end
      pcm_pkg::SYNTH_OFS:   rdata_d[5:0]        = synth_q;
      pcm_pkg::REFERENCE_DIVIDER_OFS:  rdata_d[5:0]        = reference_divider_q;
      pcm_pkg::PLL_POST_DIVIDER_OFS: rdata_d[4:0]        = post_q;
      pcm_pkg::FILT_OFS:    rdata_d[FILT_W-1:0] = spike_filter_setting_q;
      pcm_pkg::STATUS_OFS: begin
        rdata_d[pcm_pkg::STAT_MODE_LSB +: 2] = mode_q;
        rdata_d[pcm_pkg::STAT_LOCK_BIT]      = lock_q;
        rdata_d[pcm_pkg::STAT_QUAL_BIT]      = osc_qualified_flag;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll configuration registers; oscillator failure in external pll mode reloads defaults

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      synth_q                <= pcm_pkg::SYNTH_RST;
      reference_divider_q               <= pcm_pkg::REFERENCE_DIVIDER_RST;
      post_q                 <= pcm_pkg::PLL_POST_DIVIDER_RST;
      spike_filter_setting_q <= pcm_pkg::FILT_RST[FILT_W-1:0];
    end else if (qual_fall_w && mode_q == pcm_pkg::PLL_EXTERNAL_REF_MODE) begin
      synth_q  <= pcm_pkg::SYNTH_RST;
      reference_divider_q <= pcm_pkg::REFERENCE_DIVIDER_RST;
      post_q   <= pcm_pkg::PLL_POST_DIVIDER_RST;
    end else if (wr_w) begin
      // dividers are expected to be set before oscillator enable
      if (paddr_in == pcm_pkg::SYNTH_OFS)   synth_q  <= pwdata_in[5:0];
      if (paddr_in == pcm_pkg::REFERENCE_DIVIDER_OFS)  reference_divider_q <= pwdata_in[5:0];
      if (paddr_in == pcm_pkg::PLL_POST_DIVIDER_OFS) post_q   <= pwdata_in[4:0];
      if (paddr_in == pcm_pkg::FILT_OFS)
        spike_filter_setting_q <= pwdata_in[FILT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits: hardware setting of pll select wins over a software clear

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_enable_bit_q <= pcm_pkg::CTRL_RST[pcm_pkg::CTRL_OSC_ENABLE_BIT_BIT];
      pll_select_bit_q <= pcm_pkg::CTRL_RST[pcm_pkg::CTRL_PLL_SELECT_BIT_BIT];
      wd_sel_q         <= pcm_pkg::CTRL_RST[pcm_pkg::CTRL_WDSEL_BIT];
      rt_sel_q         <= pcm_pkg::CTRL_RST[pcm_pkg::CTRL_RTSEL_BIT];
    end else if (full_stop_exit_in) begin
      osc_enable_bit_q <= 1'b0;
      pll_select_bit_q <= 1'b1;
    end else begin
      if (wr_w && paddr_in == pcm_pkg::CTRL_OFS) begin
        osc_enable_bit_q <= pwdata_in[pcm_pkg::CTRL_OSC_ENABLE_BIT_BIT];
        pll_select_bit_q <= pwdata_in[pcm_pkg::CTRL_PLL_SELECT_BIT_BIT];
        wd_sel_q         <= pwdata_in[pcm_pkg::CTRL_WDSEL_BIT];
        rt_sel_q         <= pwdata_in[pcm_pkg::CTRL_RTSEL_BIT];
      end
      if (qual_fall_w && mode_q == pcm_pkg::PLL_EXTERNAL_REF_MODE)
        osc_enable_bit_q <= 1'b0;
      if (qual_fall_w || !osc_qualified_flag)
        pll_select_bit_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator qualification

  pcm_spike_filter #(
    .FILT_W (FILT_W)
  ) u_filter (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .enable_in     (osc_enable_bit_q && pll_lock_in),
    .vco_tick_in   (vco_tick_in),
    .osc_level_in  (osc_level_in),
    .setting_in    (spike_filter_setting_q),
    .qualified_out (filt_qual_w)
  );

  // the flag follows the filter, and drops at once when lock goes
  assign osc_qualified_flag = filt_qual_w && pll_lock_in;
  assign lock_fall_w        = lock_q && !pll_lock_in;
  assign qual_fall_w        = lock_fall_w || (qualified_prev_q && !osc_qualified_flag);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lock_q           <= 1'b0;
      qualified_prev_q <= 1'b0;
    end else begin
      lock_q           <= pll_lock_in;
      qualified_prev_q <= osc_qualified_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  always_comb begin
    if (!osc_enable_bit_q)
      mode_d = pcm_pkg::PLL_INTERNAL_REF_MODE;
    else if (osc_qualified_flag && !pll_select_bit_q)
      mode_d = pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE;
    else
      mode_d = pcm_pkg::PLL_EXTERNAL_REF_MODE;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in)
      mode_q <= pcm_pkg::PLL_INTERNAL_REF_MODE;
    else
      mode_q <= mode_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // glitch-free bus source switch: gate both off, swap in mid-gap so the source
  // never changes while the gate is open

  assign want_osc_w = (mode_d == pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_osc_q         <= 1'b0;
      sw_cnt_q          <= 2'h0;
      bus_switching_out <= 1'b0;
    end else if (sw_cnt_q != 2'h0) begin
      sw_cnt_q          <= sw_cnt_q - 2'h1;
      bus_switching_out <= (sw_cnt_q != 2'h1);
      if (sw_cnt_q == 2'h3)
        src_osc_q <= want_osc_w;
    end else if (want_osc_w != src_osc_q) begin
      sw_cnt_q          <= 2'h3;
      bus_switching_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the clock tree

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pll_cfg_out          <= '{pcm_pkg::SYNTH_RST, pcm_pkg::REFERENCE_DIVIDER_RST,
                                pcm_pkg::PLL_POST_DIVIDER_RST, 1'b0};
      pll_enable_out       <= 1'b1;
      osc_enable_out       <= 1'b0;
      bus_from_osc_out     <= 1'b0;
      watchdog_ext_clk_out <= 1'b0;
      rti_ext_clk_out      <= 1'b0;
      mode_out             <= pcm_pkg::PLL_INTERNAL_REF_MODE;
    end else begin
      pll_cfg_out          <= '{synth_q, reference_divider_q, post_q,
                                mode_q != pcm_pkg::PLL_INTERNAL_REF_MODE};
      pll_enable_out       <= 1'b1;
      osc_enable_out       <= osc_enable_bit_q;
      bus_from_osc_out     <= src_osc_q;
      // internal mode forces the internal reference on both timers
      watchdog_ext_clk_out <= (mode_q != pcm_pkg::PLL_INTERNAL_REF_MODE) && wd_sel_q;
      rti_ext_clk_out      <= (mode_q != pcm_pkg::PLL_INTERNAL_REF_MODE) && rt_sel_q;
      mode_out             <= mode_q;
    end
  end

endmodule : pcm_clock_mode_ctrl

// File: verification/pcm_clock_mode_chk.sv
// checker: port-level timing and mode assertions for the clock-mode controller
`timescale 1ns/1ps
module pcm_clock_mode_chk (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pll_lock_in,
  input wire logic                  full_stop_exit_in,
  input wire pcm_pkg::pcm_pll_cfg_s pll_cfg_out,
  input wire logic                  pll_enable_out,
  input wire logic                  osc_enable_out,
  input wire logic                  bus_from_osc_out,
  input wire logic                  bus_switching_out,
  input wire logic                  watchdog_ext_clk_out,
  input wire logic                  rti_ext_clk_out,
  input wire pcm_pkg::pcm_mode_e    mode_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // reset checks must run while reset is high, so they turn the default disable off
  chk_reset_mode: assert property (disable iff (1'b0) rst_in |=>
    mode_out == pcm_pkg::PLL_INTERNAL_REF_MODE && !osc_enable_out && !bus_from_osc_out)
    else $error("mode not internal after reset");
  chk_reset_cfg: assert property (disable iff (1'b0) rst_in |=>
    pll_cfg_out.synth == pcm_pkg::SYNTH_RST && pll_cfg_out.pll_post_divider == pcm_pkg::PLL_POST_DIVIDER_RST)
    else $error("pll setting not default after reset");
  chk_pll_on: assert property (pll_enable_out)
    else $error("pll stopped");
  chk_internal_tmr: assert property ((!osc_enable_out) [*4] |->
    mode_out == pcm_pkg::PLL_INTERNAL_REF_MODE && !watchdog_ext_clk_out && !rti_ext_clk_out)
    else $error("oscillator off but not internal mode");
  chk_switch_len: assert property ($rose(bus_switching_out) |=>
    bus_switching_out ##1 bus_switching_out ##1 !bus_switching_out)
    else $error("switch gap not three cycles");
  chk_switch_src: assert property ($changed(bus_from_osc_out) |->
    bus_switching_out && $past(bus_switching_out))
    else $error("bus source flipped without gap");
  chk_lock_exit: assert property (mode_out == pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE &&
    !pll_lock_in |-> ##[1:4] mode_out != pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE)
    else $error("bypass kept after lock loss");
  chk_osc_fail: assert property ($fell(pll_lock_in) &&
    mode_out == pcm_pkg::PLL_EXTERNAL_REF_MODE && $past(osc_enable_out) |->
    ##[1:4] !osc_enable_out && pll_cfg_out.synth == pcm_pkg::SYNTH_RST)
    else $error("no fallback on oscillator failure");
  chk_stop_exit: assert property (full_stop_exit_in |-> ##[1:2] !osc_enable_out)
    else $error("oscillator kept after full stop");
  chk_apb_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  chk_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule : pcm_clock_mode_chk

bind pcm_clock_mode_ctrl pcm_clock_mode_chk i_pcm_clock_mode_chk (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pll_lock_in(pll_lock_in), .full_stop_exit_in(full_stop_exit_in),
  .pll_cfg_out(pll_cfg_out), .pll_enable_out(pll_enable_out),
  .osc_enable_out(osc_enable_out), .bus_from_osc_out(bus_from_osc_out),
  .bus_switching_out(bus_switching_out), .watchdog_ext_clk_out(watchdog_ext_clk_out),
  .rti_ext_clk_out(rti_ext_clk_out), .mode_out(mode_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out));

// File: verification/pcm_osc_model.sv
// partner model: crystal oscillator and analog pll lock seen by the controller
`timescale 1ns/1ps
module pcm_osc_model #(
  parameter int HALF     = 4,
  parameter int LOCK_DLY = 20
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic osc_on_in,
  input  wire logic lock_ok_in,
  output logic      osc_level_out,
  output logic      vco_tick_out,
  output logic      pll_lock_out
);
  int ph_q;
  int lk_q;
  // crystal runs only while enabled; a stopped crystal rests low
  always_ff @(posedge clk_in) begin
    if (rst_in || !osc_on_in) begin
      ph_q <= 0;
      osc_level_out <= 1'b0;
    end else if (ph_q == HALF - 1) begin
      ph_q <= 0;
      osc_level_out <= !osc_level_out;
    end else begin
      ph_q <= ph_q + 1;
    end
  end
  // vco sampled every cycle: eight samples per crystal period
  assign vco_tick_out = !rst_in;
  // lock needs settle time and drops at once on a disturbance
  always_ff @(posedge clk_in) begin
    if (rst_in || !lock_ok_in) lk_q <= 0;
    else if (lk_q < LOCK_DLY) lk_q <= lk_q + 1;
  end
  assign pll_lock_out = (lk_q == LOCK_DLY);
endmodule : pcm_osc_model

// File: verification/tb_top.sv
// testbench: apb-driven clock-mode scenarios against the oscillator model
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fse = 1'b0, lock_ok = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, lock, tick, osc, pll_en, osc_en, from_osc, sw, wd, rt;
  pcm_pkg::pcm_pll_cfg_s cfg;
  pcm_pkg::pcm_mode_e mode;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  pcm_clock_mode_ctrl i_pcm_clock_mode_ctrl (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pll_lock_in(lock), .vco_tick_in(tick), .osc_level_in(osc), .full_stop_exit_in(fse),
    .pll_cfg_out(cfg), .pll_enable_out(pll_en), .osc_enable_out(osc_en),
    .bus_from_osc_out(from_osc), .bus_switching_out(sw), .watchdog_ext_clk_out(wd),
    .rti_ext_clk_out(rt), .mode_out(mode));
  pcm_osc_model i_pcm_osc_model (.clk_in(clk_in), .rst_in(rst_in), .osc_on_in(osc_en),
    .lock_ok_in(lock_ok), .osc_level_out(osc), .vco_tick_out(tick), .pll_lock_out(lock));
  ////////////////////////////////////////////////////////////////////////////////
  // values read right after an edge are those that edge sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      $display("Error %0t: apb answer missing", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd_chk
  task automatic wait_mode(input pcm_pkg::pcm_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(mode, m)
  endtask : wait_mode
  // qualification takes eight crystal periods after lock, so poll with a bound
  task automatic wait_qual;
    int n;
    n = 0;
    rdat = 32'h0;
    while (rdat[pcm_pkg::STAT_QUAL_BIT] !== 1'b1 && n < 100) begin
      apb(1'b0, pcm_pkg::STATUS_OFS, 32'h0);
      n++;
    end
    `CHK(rdat[pcm_pkg::STAT_QUAL_BIT], 1'b1)
  endtask : wait_qual
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk_in = !clk_in;
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(pcm_pkg::CTRL_OFS, 32'h2);
    rd_chk(pcm_pkg::SYNTH_OFS, 32'h1F);
    rd_chk(pcm_pkg::REFERENCE_DIVIDER_OFS, 32'h0);
    rd_chk(pcm_pkg::PLL_POST_DIVIDER_OFS, 32'h3);
    rd_chk(pcm_pkg::FILT_OFS, 32'h0);
    `CHK(cfg, {pcm_pkg::SYNTH_RST, pcm_pkg::REFERENCE_DIVIDER_RST, pcm_pkg::PLL_POST_DIVIDER_RST, 1'b0})
    rd_chk(12'h018, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hE);
    repeat (4) @(posedge clk_in);
    `CHK({wd, rt}, 2'h0)
    $display("test reset done");
    apb(1'b1, pcm_pkg::SYNTH_OFS, 32'h7);
    apb(1'b1, pcm_pkg::REFERENCE_DIVIDER_OFS, 32'h1);
    apb(1'b1, pcm_pkg::PLL_POST_DIVIDER_OFS, 32'h1);
    apb(1'b1, pcm_pkg::FILT_OFS, 32'h4);
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hF);
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    `CHK({cfg.synth, cfg.ext_ref, wd, rt}, {6'h07, 3'h7})
    wait_qual();
    $display("test external done");
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hD);
    wait_mode(pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE);
    repeat (6) @(posedge clk_in);
    `CHK({from_osc, pll_en, rt}, 3'h7)
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hF);
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    repeat (6) @(posedge clk_in);
    `CHK(from_osc, 1'b0)
    $display("test bypass done");
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hD);
    wait_mode(pcm_pkg::PLL_BYPASSED_EXTERNAL_MODE);
    lock_ok <= 1'b0;
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    rd_chk(pcm_pkg::CTRL_OFS, 32'hF);
    rd_chk(pcm_pkg::STATUS_OFS, 32'h1);
    `CHK(from_osc, 1'b0)
    lock_ok <= 1'b1;
    wait_qual();
    lock_ok <= 1'b0;
    wait_mode(pcm_pkg::PLL_INTERNAL_REF_MODE);
    `CHK(cfg, {pcm_pkg::SYNTH_RST, pcm_pkg::REFERENCE_DIVIDER_RST, pcm_pkg::PLL_POST_DIVIDER_RST, 1'b0})
    rd_chk(pcm_pkg::CTRL_OFS, 32'hE);
    lock_ok <= 1'b1;
    $display("test loss done");
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hF);
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'h2);
    wait_mode(pcm_pkg::PLL_INTERNAL_REF_MODE);
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hF);
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    fse <= 1'b1;
    @(posedge clk_in);
    fse <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK(osc_en, 1'b0)
    wait_mode(pcm_pkg::PLL_INTERNAL_REF_MODE);
    rd_chk(pcm_pkg::CTRL_OFS, 32'hE);
    $display("test stop done");
    apb(1'b1, pcm_pkg::CTRL_OFS, 32'hF);
    wait_mode(pcm_pkg::PLL_EXTERNAL_REF_MODE);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    `CHK({mode, osc_en}, 3'h0)
    rd_chk(pcm_pkg::CTRL_OFS, 32'h2);
    $display("test rerun done");
    tally_and_finish();
  end
endmodule : tb_top
